// [ccs_pkg.sv]
package ccs_pkg;
    // ==================================================
    // Register map (byte addresses)
    localparam logic [7:0]  CTRL_OFS     = 8'h00;
    localparam logic [7:0]  DIV_OFS      = 8'h04;
    localparam logic [7:0]  DLY_OFS      = 8'h08;
    localparam logic [7:0]  STAT_OFS     = 8'h0C;
    localparam logic [7:0]  PER_OFS      = 8'h10;
    localparam logic [7:0]  ODLY_OFS     = 8'h14;
    localparam int          NUM_OUTS     = 5;
    // ==================================================
    // Control fields
    localparam int          C_SITE_RST   = 0;
    localparam int          C_LOOP_EN    = 1;
    localparam int          C_SYS_BYP    = 2;
    localparam int          C_FB_BYP     = 3;
    localparam int          C_CORE1_EN   = 4;
    localparam int          C_CORE2_EN   = 5;
    localparam int          C_EXT_A      = 6;
    localparam int          C_EXT_B      = 7;
    localparam int          C_EXT_C      = 8;
    localparam logic [8:0]  CTRL_RESET   = 9'h001;
    // ==================================================
    // Divider fields, each stores factor minus one
    localparam int          D_IN_LSB     = 0;
    localparam int          D_FB_LSB     = 7;
    localparam int          D_U_LSB      = 14;
    localparam int          D_V_LSB      = 19;
    localparam int          D_W_LSB      = 24;
    localparam int          IN_DIV_W     = 7;
    localparam int          OUT_DIV_W    = 5;
    localparam logic [28:0] DIV_RESET    = 29'h0000_0000;
    // ==================================================
    // Delay select fields, five bits each
    localparam int          S_FB_LSB     = 0;
    localparam int          S_GLA_LSB    = 5;
    localparam int          S_GLB_LSB    = 10;
    localparam int          S_GLC_LSB    = 15;
    localparam int          S_YB_LSB     = 20;
    localparam int          S_YC_LSB     = 25;
    localparam int          SEL_W        = 5;
    localparam logic [29:0] DLY_RESET    = 30'h0000_0000;
    // ==================================================
    // Nominal delays in picoseconds
    localparam logic [31:0] SYS_DELAY_PS = 32'h0000_07D0;
    localparam logic [31:0] FB_MIN_PS    = 32'h0000_0258;
    localparam logic [31:0] FB_STEP_PS   = 32'h0000_00A0;
    localparam logic [31:0] FB_MAX_PS    = 32'h0000_15B8;
    localparam logic [31:0] GL_DRV_PS    = 32'h0000_02F3;
    localparam logic [31:0] GL_STEP_PS   = 32'h0000_00C8;
    localparam logic [31:0] GL_MAX_PS    = 32'h0000_1A4F;
    // ==================================================
    // Site operating mode
    typedef enum logic [1:0] {
        MODE_HOLD       = 2'b00,
        MODE_LOOP       = 2'b01,
        MODE_DELAY_ONLY = 2'b10
    } mode_t;
endpackage

// [clock_conditioning_site.sv]
// Summary of operation
// - Input and feedback dividers take any integer factor 1 to 128.
// - Each of three output dividers takes any integer factor 1 to 32.
// - Primary rate is reference times feedback over input times primary.
// - Secondary one global and core outputs run at ref*m/(n*v).
// - Secondary two global and core outputs run at ref*m/(n*w).
// - All five outputs share one input and one feedback divider.
// - Seven delay elements: two in feedback, one per output.
// - Fixed system feedback delay is nominally 2 ns.
// - Feedback delay selectable 0.6 to 5.56 ns in 160 ps steps.
// - System and feedback delays each have an independent bypass.
// - Feedback path delay advances outputs, acting as negative delay.
// - Each global output adds a fixed 0.755 ns driver delay.
// - Global delay steps 200 ps from its start, up to 6.735 ns.
// - Core outputs offer 0.6 to 5.56 ns delay in 160 ps steps.
// - Delay-only paths use the same delay elements as the loop.
// - Loop unused: three delay-only paths, own input, own delay.
// - Loop unused: primary global may pass input through delay only.
// - Primary-only loop frees two globals; three used blocks the loop.
// - A secondary core output used alone reserves one global network.
module clock_conditioning_site
    import ccs_pkg::*;
#(
    parameter logic [31:0] GL_START_PS = 32'h0000_0000,
    parameter int          PER_W       = 16
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        reference_clock_in,
    input  wire logic [2:0]  delay_only_path,
    output logic             primary_global_out,
    output logic             secondary_global_out_one,
    output logic             secondary_global_out_two,
    output logic             core_out_one,
    output logic             core_out_two,
    output logic             loop_active
);
    import ccs_pkg::*;

    // ==================================================
    // Helpers
    function automatic logic [31:0] step_ps(input logic [31:0] base,
                                            input logic [31:0] step,
                                            input logic [4:0]  sel);
        step_ps = base + step * {27'h000_0000, sel};
    endfunction

    function automatic logic [32:0] nco(input logic [31:0] acc,
                                        input logic [31:0] inc,
                                        input logic [31:0] lim);
        logic [31:0] sum;
        sum = acc + inc;
        if (sum >= lim) begin
            nco = {1'b1, sum - lim};
        end else begin
            nco = {1'b0, sum};
        end
    endfunction

    // ==================================================
    // Configuration registers
    logic [8:0]  ctrl_q;
    logic [28:0] div_q;
    logic [29:0] dly_q;
    logic        wr_en;
    logic        rd_en;
    logic        site_rst;
    logic        mapped;
    logic        locked_wr;

    assign site_rst  = ctrl_q[C_SITE_RST];
    assign wr_en     = psel && penable && pwrite;
    assign rd_en     = psel && !penable && !pwrite;
    assign mapped    = (paddr[1:0] == 2'b00) &&
                       (paddr <= ODLY_OFS + 8'h10);
    assign locked_wr = !site_rst &&
                       (paddr == DIV_OFS || paddr == DLY_OFS);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_en && paddr == CTRL_OFS) begin
            ctrl_q[C_SITE_RST] <= pwdata[C_SITE_RST];
            if (site_rst) begin
                ctrl_q[8:1] <= pwdata[8:1];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_q <= DIV_RESET;
            dly_q <= DLY_RESET;
        end else if (wr_en && site_rst) begin
            if (paddr == DIV_OFS) begin
                div_q <= pwdata[28:0];
            end
            if (paddr == DLY_OFS) begin
                dly_q <= pwdata[29:0];
            end
        end
    end

    // ==================================================
    // Divider factors, field plus one
    logic [7:0]  n_fac;
    logic [7:0]  m_fac;
    logic [5:0]  o_fac [3];

    assign n_fac    = {1'b0, div_q[D_IN_LSB +: IN_DIV_W]} + 8'h01;
    assign m_fac    = {1'b0, div_q[D_FB_LSB +: IN_DIV_W]} + 8'h01;
    assign o_fac[0] = {1'b0, div_q[D_U_LSB +: OUT_DIV_W]} + 6'h01;
    assign o_fac[1] = {1'b0, div_q[D_V_LSB +: OUT_DIV_W]} + 6'h01;
    assign o_fac[2] = {1'b0, div_q[D_W_LSB +: OUT_DIV_W]} + 6'h01;

    // ==================================================
    // Global network sharing
    logic [2:0] ext_used;
    logic       loop_blocked;
    logic [2:0] reserved;
    logic       conflict;
    mode_t      mode;

    assign ext_used     = ctrl_q[C_EXT_C:C_EXT_A];
    assign loop_blocked = &ext_used;
    assign reserved[0]  = loop_active || ext_used[0];
    assign reserved[1]  = (loop_active && ctrl_q[C_CORE1_EN]) ||
                          ext_used[1];
    assign reserved[2]  = (loop_active && ctrl_q[C_CORE2_EN]) ||
                          ext_used[2];
    assign conflict     = ctrl_q[C_LOOP_EN] && (ext_used[0] ||
                          (ctrl_q[C_CORE1_EN] && ext_used[1]) ||
                          (ctrl_q[C_CORE2_EN] && ext_used[2]));

    always_comb begin
        if (site_rst) begin
            mode = MODE_HOLD;
        end else if (ctrl_q[C_LOOP_EN] && !loop_blocked) begin
            mode = MODE_LOOP;
        end else begin
            mode = MODE_DELAY_ONLY;
        end
    end

    // ==================================================
    // Reference period measurement in core cycles
    logic             ref_q;
    logic             seen_q;
    logic [PER_W-1:0] cnt_q;
    logic [PER_W-1:0] period_q;
    logic             ref_rise;

    assign ref_rise = reference_clock_in && !ref_q;

    // Tracks the pin through site reset, so no false edge on release
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= reference_clock_in;
        end
    end

    // First rising edge only starts the count
    always_ff @(posedge core_clk) begin
        if (rst || site_rst) begin
            seen_q   <= 1'b0;
            cnt_q    <= '0;
            period_q <= '0;
        end else if (ref_rise) begin
            seen_q <= 1'b1;
            cnt_q  <= '0;
            if (seen_q) begin
                period_q <= cnt_q + 1'b1;
            end
        end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // ==================================================
    // Loop model: per-output phase accumulators
    // Adds 2*m per cycle; toggles when n*o*period is reached.
    // Output must stay below half the core clock rate.
    logic [31:0] acc_q [3];
    logic [2:0]  tog_q;
    logic [31:0] inc;
    logic [31:0] lim [3];

    assign inc = {23'h00_0000, m_fac, 1'b0};

    always_comb begin
        for (int k = 0; k < 3; k++) begin
            lim[k] = {24'h00_0000, n_fac} * {26'h000_0000, o_fac[k]} *
                     {{(32-PER_W){1'b0}}, period_q};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || mode != MODE_LOOP || period_q == '0) begin
            for (int k = 0; k < 3; k++) begin
                acc_q[k] <= 32'h0000_0000;
            end
            tog_q       <= 3'b000;
            loop_active <= 1'b0;
        end else begin
            loop_active <= 1'b1;
            for (int k = 0; k < 3; k++) begin
                {tog_q[k], acc_q[k]} <= nco(acc_q[k], inc, lim[k])
                                        ^ {tog_q[k], 32'h0000_0000};
            end
        end
    end

    // ==================================================
    // Output selection
    always_ff @(posedge core_clk) begin
        if (rst) begin
            primary_global_out       <= 1'b0;
            secondary_global_out_one <= 1'b0;
            secondary_global_out_two <= 1'b0;
            core_out_one             <= 1'b0;
            core_out_two             <= 1'b0;
        end else begin
            case (mode)
                MODE_LOOP: begin
                    primary_global_out       <= tog_q[0];
                    secondary_global_out_one <= tog_q[1];
                    secondary_global_out_two <= tog_q[2];
                    core_out_one <= tog_q[1] && ctrl_q[C_CORE1_EN];
                    core_out_two <= tog_q[2] && ctrl_q[C_CORE2_EN];
                end
                MODE_DELAY_ONLY: begin
                    primary_global_out       <= delay_only_path[0];
                    secondary_global_out_one <= delay_only_path[1];
                    secondary_global_out_two <= delay_only_path[2];
                    core_out_one             <= 1'b0;
                    core_out_two             <= 1'b0;
                end
                default: begin
                    primary_global_out       <= 1'b0;
                    secondary_global_out_one <= 1'b0;
                    secondary_global_out_two <= 1'b0;
                    core_out_one             <= 1'b0;
                    core_out_two             <= 1'b0;
                end
            endcase
        end
    end

    // ==================================================
    // Delay elements, nominal picoseconds
    logic [31:0] fb_ps;
    logic [31:0] adv_ps;
    logic [31:0] gl_ps [3];
    logic [31:0] raw_ps [NUM_OUTS];
    logic [31:0] odly_q [NUM_OUTS];

    assign fb_ps = step_ps(FB_MIN_PS, FB_STEP_PS,
                           dly_q[S_FB_LSB +: SEL_W]);
    assign adv_ps = (ctrl_q[C_SYS_BYP] ? 32'h0000_0000 : SYS_DELAY_PS) +
                    (ctrl_q[C_FB_BYP]  ? 32'h0000_0000 : fb_ps);

    always_comb begin
        for (int k = 0; k < 3; k++) begin
            gl_ps[k] = step_ps(GL_START_PS, GL_STEP_PS,
                               dly_q[S_GLA_LSB + k*SEL_W +: SEL_W]);
            if (gl_ps[k] > GL_MAX_PS) begin
                gl_ps[k] = GL_MAX_PS;
            end
            raw_ps[k] = GL_DRV_PS + gl_ps[k];
        end
        raw_ps[3] = step_ps(FB_MIN_PS, FB_STEP_PS,
                            dly_q[S_YB_LSB +: SEL_W]);
        raw_ps[4] = step_ps(FB_MIN_PS, FB_STEP_PS,
                            dly_q[S_YC_LSB +: SEL_W]);
    end

    // Seven elements: two feedback, five outputs
    always_ff @(posedge core_clk) begin
        for (int k = 0; k < NUM_OUTS; k++) begin
            if (rst) begin
                odly_q[k] <= 32'h0000_0000;
            end else if (mode == MODE_LOOP) begin
                odly_q[k] <= raw_ps[k] - adv_ps;
            end else begin
                odly_q[k] <= raw_ps[k];
            end
        end
    end

    // ==================================================
    // APB slave, zero wait states, data captured in setup
    logic [31:0] rdata_d;
    logic        err_q;

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            CTRL_OFS: rdata_d = {23'h00_0000, ctrl_q};
            DIV_OFS:  rdata_d = {3'b000, div_q};
            DLY_OFS:  rdata_d = {2'b00, dly_q};
            STAT_OFS: rdata_d = {24'h00_0000, mode, conflict, reserved,
                                 loop_blocked, loop_active};
            PER_OFS:  rdata_d = {{(32-PER_W){1'b0}}, period_q};
            default: begin
                for (int k = 0; k < NUM_OUTS; k++) begin
                    if (paddr == ODLY_OFS + 8'(4*k)) begin
                        rdata_d = odly_q[k];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            err_q  <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= rd_en ? rdata_d : 32'h0000_0000;
            err_q  <= !mapped || (pwrite && (locked_wr ||
                      paddr >= STAT_OFS));
        end
    end

    assign pready  = psel && penable;
    assign pslverr = psel && penable && err_q;

    // ==================================================
    // Checks
    a_div_locked: assert property (@(posedge core_clk) disable iff (rst)
        !site_rst |=> $stable(div_q) && $stable(dly_q))
        else $error("divider or delay changed outside reset");
    a_in_range: assert property (@(posedge core_clk) disable iff (rst)
        n_fac != 8'h00 && n_fac <= 8'h80 && m_fac != 8'h00 && m_fac <= 8'h80)
        else $error("input or feedback factor out of range");
    a_out_range: assert property (@(posedge core_clk) disable iff (rst)
        o_fac[0] != 6'h00 && o_fac[0] <= 6'h20 && o_fac[1] != 6'h00 &&
        o_fac[1] <= 6'h20 && o_fac[2] != 6'h00 && o_fac[2] <= 6'h20)
        else $error("output factor out of range");
    a_fb_span: assert property (@(posedge core_clk) disable iff (rst)
        fb_ps >= FB_MIN_PS && fb_ps <= FB_MAX_PS)
        else $error("feedback delay outside span");
    a_bypass_adv: assert property (@(posedge core_clk) disable iff (rst)
        ctrl_q[C_SYS_BYP] && ctrl_q[C_FB_BYP] |-> adv_ps == 32'h0000_0000)
        else $error("bypassed feedback still adds delay");
    a_adv_neg: assert property (@(posedge core_clk) disable iff (rst)
        mode == MODE_LOOP ##1 mode == MODE_LOOP && $stable(dly_q)
        |-> odly_q[0] + adv_ps == raw_ps[0])
        else $error("feedback advance not subtracted");
    a_gl_driver: assert property (@(posedge core_clk) disable iff (rst)
        raw_ps[1] >= GL_DRV_PS + GL_START_PS &&
        raw_ps[2] <= GL_DRV_PS + GL_MAX_PS)
        else $error("global driver delay missing");
    a_loop_block: assert property (@(posedge core_clk) disable iff (rst)
        loop_blocked |=> !loop_active)
        else $error("loop ran with all globals taken");
    a_core_rsv: assert property (@(posedge core_clk) disable iff (rst)
        loop_active && ctrl_q[C_CORE1_EN] |-> reserved[1])
        else $error("core output did not reserve a global");
    a_dly_pass: assert property (@(posedge core_clk) disable iff (rst)
        mode == MODE_DELAY_ONLY
        |=> primary_global_out == $past(delay_only_path[0]))
        else $error("primary global not passing delay path");
    a_core_gate: assert property (@(posedge core_clk) disable iff (rst)
        !ctrl_q[C_CORE1_EN] ##1 !ctrl_q[C_CORE1_EN] |-> !core_out_one)
        else $error("core output one active while disabled");

    c_loop_run: cover property (@(posedge core_clk) disable iff (rst)
        loop_active ##1 $rose(primary_global_out));
    c_dly_only: cover property (@(posedge core_clk) disable iff (rst)
        mode == MODE_DELAY_ONLY ##1 $rose(secondary_global_out_two));
    c_locked: cover property (@(posedge core_clk) disable iff (rst)
        pslverr && pwrite);
endmodule

// [fabric_clock_sink.sv]
module fabric_clock_sink #(
    parameter int REF_HALF = 20
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clear,
    input  wire logic [4:0]  clk_in,
    output logic             reference_clock_in,
    output logic [4:0][15:0] edge_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] prev_q;
    int         ref_cnt_q;
    // ==================================================
    // Reference source, locked to the core clock
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ref_cnt_q          <= 0;
            reference_clock_in <= 1'b0;
        end else if (ref_cnt_q == REF_HALF - 1) begin
            ref_cnt_q          <= 0;
            reference_clock_in <= ~reference_clock_in;
        end else begin
            ref_cnt_q <= ref_cnt_q + 1;
        end
    end
    // ==================================================
    // Rising edge counters of the five clocks
    always_ff @(posedge core_clk) begin
        prev_q <= clk_in;
        for (int i = 0; i < 5; i++) begin
            if (rst || clear) begin
                edge_cnt[i] <= 16'h0000;
            end else if (clk_in[i] && !prev_q[i]) begin
                edge_cnt[i] <= edge_cnt[i] + 16'h0001;
            end
        end
    end
endmodule

// [tb_clock_conditioning_divider_delay.sv]
module tb_clock_conditioning_divider_delay import ccs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic             core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic             loop_active, clear, reference_clock_in;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata;
    logic [2:0]       dop;
    logic [4:0]       outs;
    logic [4:0][15:0] edge_cnt;
    int               n_fail, samples_checked, cyc;

    clock_conditioning_site #(.GL_START_PS(32'h0000_02DF), .PER_W(16)) dut_u (
        .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .reference_clock_in(reference_clock_in), .delay_only_path(dop),
        .primary_global_out(outs[0]), .secondary_global_out_one(outs[1]),
        .secondary_global_out_two(outs[2]), .core_out_one(outs[3]),
        .core_out_two(outs[4]), .loop_active(loop_active));
    fabric_clock_sink #(.REF_HALF(20)) sink_u (
        .core_clk(core_clk), .rst(rst), .clear(clear), .clk_in(outs),
        .reference_clock_in(reference_clock_in), .edge_cnt(edge_cnt));
    // ==================================================
    // Checking and bus helpers
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic near(input logic [15:0] got, input int exp);
        if (got >= exp - 1 && got <= exp + 1) chk(32'(exp), 32'(exp));
        else chk({16'h0000, got}, 32'(exp));
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, {31'h0, ee});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] x, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk({31'h0, e}, {31'h0, ee});
        if (!ee) chk(r & m, x);
    endtask
    // ==================================================
    // Scenarios
    task automatic t_reset;
        chk({27'h0, outs}, 32'h0000_0000);
        rd(CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0001, 1'b0);
        rd(DIV_OFS, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
        rd(DLY_OFS, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
        rd(8'h40, 32'h0000_0000, 32'h0000_0000, 1'b1);
        rd(8'h02, 32'h0000_0000, 32'h0000_0000, 1'b1);
        wr(STAT_OFS, 32'h0000_0000, 1'b1);
        wr(DIV_OFS, 32'h1FFF_FFFF, 1'b0);
        rd(DIV_OFS, 32'hFFFF_FFFF, 32'h1FFF_FFFF, 1'b0);
    endtask
    task automatic t_freq;
        int k;
        wr(CTRL_OFS, 32'h0000_0033, 1'b0);
        wr(DIV_OFS, 32'h0018_4080, 1'b0);
        wr(CTRL_OFS, 32'h0000_0032, 1'b0);
        k = 0;
        while (loop_active !== 1'b1 && k < 300) begin
            @(posedge core_clk);
            k++;
        end
        chk({31'h0, loop_active}, 32'h0000_0001);
        rd(PER_OFS, 32'hFFFF_FFFF, 32'h0000_0028, 1'b0);
        clear <= 1'b1;
        @(posedge core_clk);
        clear <= 1'b0;
        repeat (1600) @(posedge core_clk);
        #1;
        near(edge_cnt[0], 40);
        near(edge_cnt[1], 20);
        near(edge_cnt[3], 20);
        near(edge_cnt[2], 80);
        near(edge_cnt[4], 80);
        wr(DIV_OFS, 32'h0000_0000, 1'b1);
        rd(DIV_OFS, 32'hFFFF_FFFF, 32'h0018_4080, 1'b0);
        wr(CTRL_OFS, 32'h0000_0000, 1'b0);
        rd(CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0032, 1'b0);
    endtask
    task automatic t_delay(input logic sb, input logic fb);
        logic [31:0] c, adv;
        c = 32'h0000_0003 | {28'h0, fb, sb, 2'b00};
        adv = (sb ? 0 : SYS_DELAY_PS) + (fb ? 0 : FB_MIN_PS + 31 * FB_STEP_PS);
        wr(CTRL_OFS, 32'h0000_0001, 1'b0);
        wr(CTRL_OFS, c, 1'b0);
        wr(DLY_OFS, 32'h01F2_FC1F, 1'b0);
        wr(CTRL_OFS, c & 32'hFFFF_FFFE, 1'b0);
        rd(ODLY_OFS, 32'hFFFF_FFFF, GL_DRV_PS + 735 - adv, 1'b0);
        rd(ODLY_OFS + 8'h04, 32'hFFFF_FFFF, GL_DRV_PS + GL_MAX_PS - adv,
           1'b0);
        rd(ODLY_OFS + 8'h08, 32'hFFFF_FFFF, GL_DRV_PS + 1735 - adv,
           1'b0);
        rd(ODLY_OFS + 8'h0C, 32'hFFFF_FFFF, FB_MAX_PS - adv, 1'b0);
        rd(ODLY_OFS + 8'h10, 32'hFFFF_FFFF, FB_MIN_PS - adv, 1'b0);
    endtask
    task automatic t_pass(input logic [2:0] v);
        logic [2:0] old;
        old = dop;
        @(posedge core_clk);
        dop <= v;
        #1 chk({29'h0, outs[2:0]}, {29'h0, old});
        @(posedge core_clk);
        #1 chk({29'h0, outs[2:0]}, {29'h0, v});
    endtask
    task automatic t_modes;
        wr(CTRL_OFS, 32'h0000_0001, 1'b0);
        wr(CTRL_OFS, 32'h0000_01C3, 1'b0);
        wr(CTRL_OFS, 32'h0000_01C2, 1'b0);
        rd(STAT_OFS, 32'h0000_00C3, 32'h0000_0082, 1'b0);
        t_pass(3'b001);
        t_pass(3'b110);
        t_pass(3'b101);
        wr(CTRL_OFS, 32'h0000_0001, 1'b0);
        wr(CTRL_OFS, 32'h0000_0183, 1'b0);
        wr(CTRL_OFS, 32'h0000_0182, 1'b0);
        rd(STAT_OFS, 32'h0000_00C2, 32'h0000_0040, 1'b0);
        wr(CTRL_OFS, 32'h0000_0001, 1'b0);
        wr(CTRL_OFS, 32'h0000_0013, 1'b0);
        wr(CTRL_OFS, 32'h0000_0012, 1'b0);
        while (loop_active !== 1'b1) @(posedge core_clk);
        rd(STAT_OFS, 32'h0000_0029, 32'h0000_0009, 1'b0);
    endtask
    // ==================================================
    // Clock, timeout and main sequence
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        cyc = 0;
        forever begin
            @(posedge core_clk);
            cyc++;
            if (cyc >= 12000) begin
                n_fail++;
                test_done();
            end
        end
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        dop = 3'b000;
        clear = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_freq();
        for (int i = 0; i < 4; i++) t_delay(i[0], i[1]);
        t_modes();
        test_done();
    end
endmodule
